// ===== pkg/mul_ext_pkg.sv
// constants and carrier types for the multiply extension datapath
// assumes a single core clock domain; operands arrive as 32-bit words
package mul_ext_pkg;

  localparam int WORD_W = 32;
  localparam int HALF_W = 16;
  localparam int GUARD_W = 4;
  localparam int DWORD_W = 64;

  // halfword fields; bit 0 is the msb, so 0:15 is [31:16]
  localparam int HI_HALF_MSB = 31;
  localparam int HI_HALF_LSB = 16;
  localparam int LO_HALF_MSB = 15;
  localparam int LO_HALF_LSB = 0;
  localparam int SIGN_BIT = 31;
  localparam int FRAC_SHIFT = 1;

  // rounding constants
  localparam logic [WORD_W-1:0] HALF_ROUND = 32'h0000_8000;
  localparam logic [DWORD_W-1:0] WORD_ROUND = 64'h0000_0000_0800_0000;

  // reset values
  localparam logic [WORD_W-1:0] ACC_RESET = 32'h0000_0000;
  localparam logic [GUARD_W-1:0] GUARD_RESET = 4'h0;

  // issued operations
  typedef enum logic [2:0] {
    OP_NONE,
    OP_HALF_S,
    OP_HALF_U,
    OP_WORD_S,
    OP_WORD_U,
    OP_LOAD_UPPER
  } mul_op_t;

  // one issued instruction with its operands
  typedef struct packed {
    mul_op_t op;
    logic round;
    logic [WORD_W-1:0] src_a;
    logic [WORD_W-1:0] src_b;
  } mul_req_t;

  // accumulator state
  typedef struct packed {
    logic [GUARD_W-1:0] guard;
    logic [WORD_W-1:0] upper;
    logic [WORD_W-1:0] lower;
  } acc_t;

endpackage : mul_ext_pkg

// ===== rtl/acc_store.sv
// accumulator store: guard bits, upper and lower words with write enables
// assumes one core clock and asynchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module acc_store
  import mul_ext_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic wr_lower,
  input wire logic wr_upper,
  input wire logic wr_guard,
  input wire acc_t wdata,
  output acc_t rdata
);

  // each word is written only when its enable is set
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= '{guard: GUARD_RESET, upper: ACC_RESET, lower: ACC_RESET};
    end else begin
      if (wr_lower) rdata.lower <= wdata.lower;
      if (wr_upper) rdata.upper <= wdata.upper;
      if (wr_guard) rdata.guard <= wdata.guard;
    end
  end

endmodule : acc_store
`default_nettype wire

// ===== rtl/multiply_extension_unit.sv
// multiply extension datapath: halfword and word products, upper load
// assumes the core issues one request per cycle with valid operands
// Function
// - signed halfword product sign-extends selected halfwords then multiplies
// - halfword products write lower word and destination, upper untouched
// - integer mode uses bits 16:31 and applies no shift
// - fraction mode uses bits 0:15 and shifts product left one
// - rounding completer adds 16h8000 to halfword product
// - unsigned halfword product zero-extends halfwords, otherwise as signed
// - signed word product places sign-extended 64-bit product in pair
// - integer unrounded word product returns low word to destination
// - rounded word product adds 32h8000000, returns high word
// - fraction word product shifts left one, returns high word
// - upper load copies source into upper word, lower unchanged
// - upper load fills four guard bits with source sign
`timescale 1ns/1ps
`default_nettype none
module multiply_extension_unit
  import mul_ext_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic req_valid,
  input wire mul_req_t req,
  input wire logic frac_mode,
  output logic dest_valid_q,
  output logic [WORD_W-1:0] dest_data_q,
  output logic [WORD_W-1:0] lower_acc_word,
  output logic [WORD_W-1:0] upper_acc_word,
  output logic [GUARD_W-1:0] guard_bits
);

  // picks the halfword by mode; big-endian 0:15 is the top half
  function automatic logic [HALF_W-1:0] pick_half(
    input logic [WORD_W-1:0] w,
    input logic frac
  );
    pick_half = frac ? w[HI_HALF_MSB:HI_HALF_LSB]
                     : w[LO_HALF_MSB:LO_HALF_LSB];
  endfunction : pick_half

  // extends a value by sign or zero as the operation asks
  function automatic logic [DWORD_W-1:0] ext64(
    input logic [WORD_W-1:0] w,
    input logic sgn
  );
    ext64 = {{WORD_W{sgn & w[SIGN_BIT]}}, w};
  endfunction : ext64

  logic is_half;
  logic is_word;
  logic is_sgn;
  logic [HALF_W-1:0] ha;
  logic [HALF_W-1:0] hb;
  logic [WORD_W-1:0] ha_ext;
  logic [WORD_W-1:0] hb_ext;
  logic [WORD_W-1:0] half_prod;
  logic [WORD_W-1:0] half_shift;
  logic [WORD_W-1:0] half_res;
  logic [DWORD_W-1:0] word_prod;
  logic [DWORD_W-1:0] word_shift;
  logic [DWORD_W-1:0] word_res;
  logic [WORD_W-1:0] dest_d;
  logic wr_lower;
  logic wr_upper;
  logic wr_guard;
  acc_t acc_w;
  acc_t acc_r;

  // operation decode
  always_comb begin
    is_half = req_valid && (req.op == OP_HALF_S || req.op == OP_HALF_U);
    is_word = req_valid && (req.op == OP_WORD_S || req.op == OP_WORD_U);
    is_sgn = (req.op == OP_HALF_S) || (req.op == OP_WORD_S);
  end

  // halfword datapath
  always_comb begin
    ha = pick_half(req.src_a, frac_mode);
    hb = pick_half(req.src_b, frac_mode);
    ha_ext = {{HALF_W{is_sgn & ha[HALF_W-1]}}, ha};
    hb_ext = {{HALF_W{is_sgn & hb[HALF_W-1]}}, hb};
    half_prod = 32'(ha_ext * hb_ext);
    half_shift = frac_mode ? (half_prod << FRAC_SHIFT) : half_prod;
    half_res = req.round ? 32'(half_shift + HALF_ROUND) : half_shift;
  end

  // word datapath
  always_comb begin
    word_prod = 64'(ext64(req.src_a, is_sgn) * ext64(req.src_b, is_sgn));
    word_shift = frac_mode ? (word_prod << FRAC_SHIFT) : word_prod;
    word_res = req.round ? 64'(word_shift + WORD_ROUND) : word_shift;
  end

  // destination word and accumulator write selection
  always_comb begin
    dest_d = '0;
    wr_lower = 1'b0;
    wr_upper = 1'b0;
    wr_guard = 1'b0;
    acc_w = acc_r;
    if (is_half) begin
      dest_d = half_res;
      acc_w.lower = half_res;
      wr_lower = 1'b1;
    end else if (is_word) begin
      if (frac_mode || req.round) begin
        dest_d = word_res[DWORD_W-1:WORD_W];
      end else begin
        dest_d = word_res[WORD_W-1:0];
      end
      acc_w.upper = word_res[DWORD_W-1:WORD_W];
      acc_w.lower = word_res[WORD_W-1:0];
      wr_lower = 1'b1;
      wr_upper = 1'b1;
    end else if (req_valid && req.op == OP_LOAD_UPPER) begin
      acc_w.upper = req.src_a;
      acc_w.guard = {GUARD_W{req.src_a[SIGN_BIT]}};
      wr_upper = 1'b1;
      wr_guard = 1'b1;
    end
  end

  // accumulator storage; no path produces a trap or exception
  acc_store u_acc (
    .clk(clk),
    .resetn(resetn),
    .wr_lower(wr_lower),
    .wr_upper(wr_upper),
    .wr_guard(wr_guard),
    .wdata(acc_w),
    .rdata(acc_r)
  );

  // destination register result
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dest_valid_q <= 1'b0;
      dest_data_q <= ACC_RESET;
    end else begin
      dest_valid_q <= is_half || is_word;
      dest_data_q <= dest_d;
    end
  end

  assign lower_acc_word = acc_r.lower;
  assign upper_acc_word = acc_r.upper;
  assign guard_bits = acc_r.guard;

  // copies of the request one edge late, read only by the checks below
  logic chk_valid_q;
  mul_req_t chk_req_q;
  logic chk_frac_q;
  logic signed [HALF_W-1:0] chk_ha;
  logic signed [HALF_W-1:0] chk_hb;
  logic signed [WORD_W-1:0] chk_half_s;
  logic [WORD_W-1:0] chk_half_u;
  logic signed [DWORD_W-1:0] chk_word_s;
  logic [DWORD_W-1:0] chk_word_u;

  // request copy; reset keeps the checks off stale operands
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      chk_valid_q <= 1'b0;
      chk_req_q <= '0;
      chk_frac_q <= 1'b0;
    end else begin
      chk_valid_q <= req_valid;
      chk_req_q <= req;
      chk_frac_q <= frac_mode;
    end
  end

  // reference products from signed and unsigned arithmetic, apart from the datapath
  always_comb begin
    chk_ha = chk_frac_q ? chk_req_q.src_a[HI_HALF_MSB:HI_HALF_LSB]
                        : chk_req_q.src_a[LO_HALF_MSB:LO_HALF_LSB];
    chk_hb = chk_frac_q ? chk_req_q.src_b[HI_HALF_MSB:HI_HALF_LSB]
                        : chk_req_q.src_b[LO_HALF_MSB:LO_HALF_LSB];
    chk_half_s = WORD_W'(chk_ha) * WORD_W'(chk_hb);
    chk_half_u = {{HALF_W{1'b0}}, chk_ha} * {{HALF_W{1'b0}}, chk_hb};
    chk_word_s = DWORD_W'($signed(chk_req_q.src_a))
               * DWORD_W'($signed(chk_req_q.src_b));
    chk_word_u = DWORD_W'(chk_req_q.src_a) * DWORD_W'(chk_req_q.src_b);
  end

  // halfword products leave the upper word alone
  a_half_upper_kept: assert property (
    @(posedge clk) disable iff (!resetn)
    is_half |=> $stable(upper_acc_word))
    else $error("upper word changed on halfword product");

  // halfword result reaches both destination and lower word
  a_half_dest_lower: assert property (
    @(posedge clk) disable iff (!resetn)
    is_half |=> dest_valid_q && dest_data_q == lower_acc_word)
    else $error("halfword dest differs from lower word");

  // rounding adds the halfword constant after any shift
  a_half_round_val: assert property (
    @(posedge clk) disable iff (!resetn)
    is_half && req.round |=>
      dest_data_q == WORD_W'($past(half_shift) + HALF_ROUND))
    else $error("halfword rounding wrong");

  // integer mode keeps the product unshifted
  a_int_no_shift: assert property (
    @(posedge clk) disable iff (!resetn)
    is_half && !frac_mode && !req.round |=>
      dest_data_q == $past(half_prod))
    else $error("integer halfword shifted");

  // integer unrounded word product returns the low word
  a_word_int_low: assert property (
    @(posedge clk) disable iff (!resetn)
    is_word && !frac_mode && !req.round |=> dest_data_q == lower_acc_word)
    else $error("integer word dest not low word");

  // rounded or fraction word product returns the high word
  a_word_high_dest: assert property (
    @(posedge clk) disable iff (!resetn)
    is_word && (frac_mode || req.round) |=> dest_data_q == upper_acc_word)
    else $error("rounded word dest not high word");

  // upper load copies the source and keeps the lower word
  a_load_upper_val: assert property (
    @(posedge clk) disable iff (!resetn)
    req_valid && req.op == OP_LOAD_UPPER |=>
      upper_acc_word == $past(req.src_a) && $stable(lower_acc_word))
    else $error("upper load wrong");

  // upper load fills the guard bits with the source sign
  a_guard_sign: assert property (
    @(posedge clk) disable iff (!resetn)
    req_valid && req.op == OP_LOAD_UPPER |=>
      guard_bits == {GUARD_W{$past(req.src_a[SIGN_BIT])}})
    else $error("guard bits not sign copies");

  // signed halfword product in integer mode
  a_half_signed_int: assert property (
    @(posedge clk) disable iff (!resetn)
    chk_valid_q && chk_req_q.op == OP_HALF_S && !chk_frac_q &&
      !chk_req_q.round |-> dest_data_q == chk_half_s)
    else $error("signed halfword product wrong");

  // unsigned halfword product in integer mode
  a_half_unsigned_int: assert property (
    @(posedge clk) disable iff (!resetn)
    chk_valid_q && chk_req_q.op == OP_HALF_U && !chk_frac_q &&
      !chk_req_q.round |-> dest_data_q == chk_half_u)
    else $error("unsigned halfword product wrong");

  // fraction mode takes the top halves and shifts left one
  a_half_frac_shift: assert property (
    @(posedge clk) disable iff (!resetn)
    chk_valid_q && chk_req_q.op == OP_HALF_S && chk_frac_q &&
      !chk_req_q.round |-> dest_data_q == (chk_half_s << FRAC_SHIFT))
    else $error("fraction halfword product wrong");

  // unsigned fraction product rounded after the shift
  a_half_round_unsigned: assert property (
    @(posedge clk) disable iff (!resetn)
    chk_valid_q && chk_req_q.op == OP_HALF_U && chk_frac_q &&
      chk_req_q.round |->
      dest_data_q == (chk_half_u << FRAC_SHIFT) + HALF_ROUND)
    else $error("rounded unsigned halfword wrong");

  // signed word product fills the accumulator pair
  a_word_signed_pair: assert property (
    @(posedge clk) disable iff (!resetn)
    chk_valid_q && chk_req_q.op == OP_WORD_S && !chk_frac_q &&
      !chk_req_q.round |-> {upper_acc_word, lower_acc_word} == chk_word_s)
    else $error("signed word pair wrong");

  // unsigned word product fills the accumulator pair
  a_word_unsigned_pair: assert property (
    @(posedge clk) disable iff (!resetn)
    chk_valid_q && chk_req_q.op == OP_WORD_U && !chk_frac_q &&
      !chk_req_q.round |-> {upper_acc_word, lower_acc_word} == chk_word_u)
    else $error("unsigned word pair wrong");

  // rounded word product keeps the whole sum in the pair
  a_word_round_sum: assert property (
    @(posedge clk) disable iff (!resetn)
    chk_valid_q && chk_req_q.op == OP_WORD_S && !chk_frac_q &&
      chk_req_q.round |->
      {upper_acc_word, lower_acc_word} == chk_word_s + WORD_ROUND)
    else $error("rounded word sum wrong");

  // fraction word product is shifted left one in the pair
  a_word_frac_shift: assert property (
    @(posedge clk) disable iff (!resetn)
    chk_valid_q && chk_req_q.op == OP_WORD_U && chk_frac_q &&
      !chk_req_q.round |->
      {upper_acc_word, lower_acc_word} == (chk_word_u << FRAC_SHIFT))
    else $error("fraction word product wrong");

  // fraction word product is shifted before rounding
  a_word_frac_round: assert property (
    @(posedge clk) disable iff (!resetn)
    chk_valid_q && chk_req_q.op == OP_WORD_S && chk_frac_q &&
      chk_req_q.round |-> {upper_acc_word, lower_acc_word} ==
      (chk_word_s << FRAC_SHIFT) + WORD_ROUND)
    else $error("rounded fraction word wrong");

  // products never touch the guard bits
  a_guard_kept_prod: assert property (
    @(posedge clk) disable iff (!resetn)
    is_half || is_word |=> $stable(guard_bits))
    else $error("guard bits changed on product");

  // only products raise the destination strobe
  a_no_dest_else: assert property (
    @(posedge clk) disable iff (!resetn)
    !(is_half || is_word) |=> !dest_valid_q)
    else $error("destination strobe without product");

endmodule : multiply_extension_unit
`default_nettype wire

// ===== bench/core_issue.sv
// core pipeline model: issues one request per call at a rising edge
// assumes the block takes the request at the next rising edge
`timescale 1ns/1ps
`default_nettype none
module core_issue
  import mul_ext_pkg::*;
(
  input wire logic clk,
  output logic req_valid,
  output mul_req_t req,
  output logic frac_mode
);
  // quiet bus at time zero
  initial begin
    req_valid = 1'b0;
    req = '0;
    frac_mode = 1'b0;
  end
  // request held until the edge that takes it
  task issue(input mul_op_t op, input logic rnd, input logic frac,
    input logic [WORD_W-1:0] a, input logic [WORD_W-1:0] b);
    @(posedge clk);
    req_valid <= 1'b1;
    req <= '{op, rnd, a, b};
    frac_mode <= frac;
  endtask : issue
  // released operands toggle so stale values never look valid
  task idle;
    @(posedge clk);
    req_valid <= 1'b0;
    req.src_a <= ~req.src_a;
    req.src_b <= ~req.src_b;
  endtask : idle
endmodule : core_issue
`default_nettype wire

// ===== bench/multiply_extension_unit_test.sv
// self-checking bench: random products, upper loads, expected-value queue
// assumes results land on the taking edge itself, checked at the next falling edge
`timescale 1ns/1ps
`default_nettype none
module multiply_extension_unit_test;
  import mul_ext_pkg::*;
  typedef struct packed {
    logic has_dest;
    logic [WORD_W-1:0] dest;
    acc_t acc;
  } note_t;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic req_valid, frac_mode, dest_valid_q, took_q = 1'b0;
  mul_req_t req;
  logic [WORD_W-1:0] dest_data_q, lower_acc_word, upper_acc_word;
  logic [GUARD_W-1:0] guard_bits;
  int bad_count = 0, checked = 0, cycles = 0, seed;
  acc_t m_acc = '0;
  note_t notes[$];
  note_t n;
  logic [WORD_W-1:0] a, b, d;
  mul_op_t op;
  logic rnd, frac;
  core_issue i_core_issue (.clk(clk), .req_valid(req_valid), .req(req),
    .frac_mode(frac_mode));
  multiply_extension_unit i_multiply_extension_unit (.clk(clk),
    .resetn(resetn), .req_valid(req_valid), .req(req),
    .frac_mode(frac_mode), .dest_valid_q(dest_valid_q),
    .dest_data_q(dest_data_q), .lower_acc_word(lower_acc_word),
    .upper_acc_word(upper_acc_word), .guard_bits(guard_bits));
  // 100 mhz clock
  always #5 clk = ~clk;
  // reference result; updates the accumulator model
  function automatic logic [WORD_W-1:0] model_op(mul_op_t o, logic r,
    logic f, logic [WORD_W-1:0] x, logic [WORD_W-1:0] y);
    logic [HALF_W-1:0] hx, hy;
    logic [DWORD_W-1:0] ex, ey, p;
    hx = f ? x[31:16] : x[15:0];
    hy = f ? y[31:16] : y[15:0];
    if (o == OP_LOAD_UPPER) begin
      m_acc.upper = x;
      m_acc.guard = {4{x[31]}};
      return 32'h0;
    end
    if (o == OP_HALF_S || o == OP_HALF_U) begin
      ex = (o == OP_HALF_S) ? {{48{hx[15]}}, hx} : {48'h0, hx};
      ey = (o == OP_HALF_S) ? {{48{hy[15]}}, hy} : {48'h0, hy};
      p = ((ex * ey) << f) + (r ? {32'h0, HALF_ROUND} : 64'h0);
      m_acc.lower = p[31:0];
      return p[31:0];
    end
    ex = (o == OP_WORD_S) ? {{32{x[31]}}, x} : {32'h0, x};
    ey = (o == OP_WORD_S) ? {{32{y[31]}}, y} : {32'h0, y};
    p = ((ex * ey) << f) + (r ? WORD_ROUND : 64'h0);
    m_acc.upper = p[63:32];
    m_acc.lower = p[31:0];
    return (r | f) ? p[63:32] : p[31:0];
  endfunction : model_op
  task check_dest(input logic v, input logic [WORD_W-1:0] got,
    input logic ev, input logic [WORD_W-1:0] exp);
    checked++;
    if (v !== ev || (ev && got !== exp)) begin
      bad_count++;
      $display("mismatch %0t dest %h/%h exp %h/%h", $time, v, got, ev, exp);
    end
  endtask : check_dest
  task check_acc(input acc_t got, input acc_t exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %0t acc %h exp %h", $time, got, exp);
    end
  endtask : check_acc
  task test_done;
    if (bad_count == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done
  // marks cycles whose result is due
  always @(posedge clk) begin
    took_q <= req_valid && req.op != OP_NONE;
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      test_done;
    end
  end
  // watcher: oldest note against settled outputs
  always @(negedge clk) begin
    if (took_q) begin
      n = notes.pop_front();
      check_dest(dest_valid_q, dest_data_q, n.has_dest, n.dest);
      check_acc({guard_bits, upper_acc_word, lower_acc_word}, n.acc);
    end else begin
      check_dest(dest_valid_q, dest_data_q, 1'b0, '0);
    end
  end
  // reset, then every op, mode and rounding choice back to back
  initial begin
    seed = 30822;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    @(negedge clk);
    check_acc({guard_bits, upper_acc_word, lower_acc_word}, '0);
    for (int i = 0; i < 240; i++) begin
      op = mul_op_t'(i % 6);
      rnd = (i / 6) % 2;
      frac = (i / 12) % 2;
      a = (i % 5 == 0) ? 32'h8000_FFFF : $random(seed);
      b = (i % 7 == 0) ? 32'h8000_8000 : $random(seed);
      i_core_issue.issue(op, rnd, frac, a, b);
      if (op != OP_NONE) begin
        d = model_op(op, rnd, frac, a, b);
        notes.push_back('{op != OP_LOAD_UPPER, d, m_acc});
      end
      if (i % 16 == 15) i_core_issue.idle;
    end
    i_core_issue.idle;
    repeat (3) @(posedge clk);
    // second reset in mid-run must clear the accumulator again
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(negedge clk);
    check_acc({guard_bits, upper_acc_word, lower_acc_word}, '0);
    repeat (2) @(posedge clk);
    test_done;
  end
endmodule : multiply_extension_unit_test
`default_nettype wire
